//--- rtl/atc_top.sv
// Asynchronous timer clocking, update-busy tracking and wake control
// Summary of operation
// - Status bit 3 picks system clock or oscillator pin; pins then claimed.
// - Switching clock source leaves counter, compare, control unprotected.
// - Async counter write sets busy bit 2 until destination loaded.
// - Async compare write sets busy bit 1 until destination loaded.
// - Async control write sets busy bit 0 until destination loaded.
// - Status bits 7 to 4 always read zero.
// - Counter reads live count; compare and control read holding registers.
// - Written value loads into destination after two oscillator rising edges.
// - Each destination has its own holding register.
// - Compare match suppressed while counter or compare transfer pending.
// - Wake logic needs one oscillator cycle to rearm before next sleep.
// - Wake starts on next timer cycle, then CPU halts four cycles.
// - Flags reach CPU domain three cycles after the timer cycle event.
// - Compare pin changes on timer tick, not through CPU synchroniser.
// - After power-save, counter reads old value until next oscillator edge.
// - Oscillator ticks stop only in power-down.
// - Hardware never changes compare or control on its own.
//
// The APB register port and the placing of the registers are this design's own decisions.
module atc_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Timer oscillator and power state
  input  wire logic        timer_osc_in_i,
  input  wire logic        power_save_i,
  input  wire logic        power_down_i,
  // Timer outputs
  output logic             compare_pin_o,
  output logic             osc_pins_claimed_o,
  output logic             compare_irq_o,
  output logic             overflow_irq_o,
  output logic             wake_o,
  output logic             cpu_halt_o
);
  localparam int unsigned PW = atc_pkg::FLAG_SYNC_CYCLES - 1;
  localparam logic [2:0] HALT_LAST = 3'(atc_pkg::WAKE_HALT_CYCLES - 1);

  initial begin
    // The pipeline slice below needs at least two stages before the flag
    if (atc_pkg::FLAG_SYNC_CYCLES < 3) begin
      $error("atc_top: flag sync needs at least three cycles");
    end
  end

  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      atc_pkg::OFS_STATUS,
      atc_pkg::OFS_COUNT,
      atc_pkg::OFS_COMPARE,
      atc_pkg::OFS_CONTROL,
      atc_pkg::OFS_FLAGS,
      atc_pkg::OFS_IRQ_EN: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // Register state
  logic            as_reg;
  logic [7:0]      count_reg;
  logic [7:0]      compare_reg;
  logic [7:0]      control_reg;
  logic [1:0]      flags_reg;
  logic [1:0]      irq_en_reg;
  logic [7:0]      frozen_reg;
  logic            freeze_reg;
  logic [PW-1:0]   cmp_pipe_reg;
  logic [PW-1:0]   ovf_pipe_reg;
  // APB outputs
  logic [31:0]     prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;
  // Timer outputs
  logic            pin_reg;
  logic            claimed_reg;
  logic            cmp_irq_reg;
  logic            ovf_irq_reg;
  logic            wake_reg;
  logic            halt_reg;
  logic [2:0]      halt_cnt_reg;
  atc_pkg::atc_wake_t wake_state_reg;

  // Internal nets
  logic       osc_rise;
  logic       tick;
  logic       run;
  logic       wr_en;
  logic       w_cnt;
  logic       w_cmp;
  logic       w_ctl;
  logic [7:0] cnt_hold;
  logic [7:0] cmp_hold;
  logic [7:0] ctl_hold;
  logic       cnt_busy;
  logic       cmp_busy;
  logic       ctl_busy;
  logic       cnt_load;
  logic       cmp_load;
  logic       ctl_load;
  logic       match_ev;
  logic       ovf_ev;
  logic [7:0] count_view;
  logic [7:0] status_view;
  logic       irq_pend;

  atc_sync3 u_osc_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (timer_osc_in_i),
    .level_o   (),
    .rise_o    (osc_rise)
  );

  // Oscillator keeps ticking in every sleep mode but power-down
  assign tick = as_reg ? (osc_rise && !power_down_i) : 1'b1;
  assign run  = |control_reg[atc_pkg::CTL_RUN_MSB:atc_pkg::CTL_RUN_LSB];

  // APB write strobes, taken only in the access cycle with pready
  assign wr_en = psel_i && penable_i && pready_reg && pwrite_i;
  assign w_cnt = wr_en && (paddr_i == atc_pkg::OFS_COUNT);
  assign w_cmp = wr_en && (paddr_i == atc_pkg::OFS_COMPARE);
  assign w_ctl = wr_en && (paddr_i == atc_pkg::OFS_CONTROL);

  // Rewrites while busy are not blocked; software must avoid them
  atc_xfer #(.W(8), .EDGES(atc_pkg::XFER_EDGES)) u_cnt_xfer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (w_cnt),
    .wdata_i   (pwdata_i[7:0]),
    .async_i   (as_reg),
    .tick_i    (tick),
    .hold_o    (cnt_hold),
    .busy_o    (cnt_busy),
    .load_o    (cnt_load)
  );

  atc_xfer #(.W(8), .EDGES(atc_pkg::XFER_EDGES)) u_cmp_xfer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (w_cmp),
    .wdata_i   (pwdata_i[7:0]),
    .async_i   (as_reg),
    .tick_i    (tick),
    .hold_o    (cmp_hold),
    .busy_o    (cmp_busy),
    .load_o    (cmp_load)
  );

  atc_xfer #(.W(8), .EDGES(atc_pkg::XFER_EDGES)) u_ctl_xfer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (w_ctl),
    .wdata_i   (pwdata_i[7:0]),
    .async_i   (as_reg),
    .tick_i    (tick),
    .hold_o    (ctl_hold),
    .busy_o    (ctl_busy),
    .load_o    (ctl_load)
  );

  // Clock source select; a switch does not flush pending transfers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      as_reg <= atc_pkg::RST_AS;
    end else if (wr_en && paddr_i == atc_pkg::OFS_STATUS) begin
      as_reg <= pwdata_i[atc_pkg::ST_AS_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      claimed_reg <= 1'b0;
    end else begin
      claimed_reg <= as_reg;
    end
  end

  // Timer events; compare is blind while counter or compare is in flight
  assign match_ev = tick && run && !cnt_load && !cnt_busy && !cmp_busy &&
                    (count_reg == compare_reg);
  assign ovf_ev   = tick && run && !cnt_load && (count_reg == 8'hff);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_reg <= atc_pkg::RST_COUNT;
    end else if (cnt_load) begin
      count_reg <= cnt_hold;
    end else if (tick && run) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // Destinations change only from their holding registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      compare_reg <= atc_pkg::RST_COMPARE;
      control_reg <= atc_pkg::RST_CONTROL;
    end else begin
      if (cmp_load) begin
        compare_reg <= cmp_hold;
      end
      if (ctl_load) begin
        control_reg <= ctl_hold;
      end
    end
  end

  // Pin follows the timer tick directly
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_reg <= 1'b0;
    end else if (match_ev && control_reg[atc_pkg::CTL_TOGGLE_BIT]) begin
      pin_reg <= !pin_reg;
    end
  end

  // Flag crossing: timer event, then a short CPU-side pipeline
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmp_pipe_reg <= '0;
      ovf_pipe_reg <= '0;
    end else begin
      cmp_pipe_reg <= {cmp_pipe_reg[PW-2:0], match_ev};
      ovf_pipe_reg <= {ovf_pipe_reg[PW-2:0], ovf_ev};
    end
  end

  // Write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flags_reg <= atc_pkg::RST_FLAGS;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == atc_pkg::FL_CMP_BIT) ? cmp_pipe_reg[PW-1]
                                       : ovf_pipe_reg[PW-1]) begin
          flags_reg[i] <= 1'b1;
        end else if (wr_en && paddr_i == atc_pkg::OFS_FLAGS &&
                     pwdata_i[i]) begin
          flags_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_en_reg <= atc_pkg::RST_IRQ_EN;
    end else if (wr_en && paddr_i == atc_pkg::OFS_IRQ_EN) begin
      irq_en_reg <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmp_irq_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
    end else begin
      cmp_irq_reg <= flags_reg[atc_pkg::FL_CMP_BIT] &&
                     irq_en_reg[atc_pkg::FL_CMP_BIT];
      ovf_irq_reg <= flags_reg[atc_pkg::FL_OVF_BIT] &&
                     irq_en_reg[atc_pkg::FL_OVF_BIT];
    end
  end

  assign irq_pend = |(flags_reg & irq_en_reg);

  // Stale count after power-save until the next oscillator edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      freeze_reg <= 1'b0;
      frozen_reg <= atc_pkg::RST_COUNT;
    end else begin
      if (as_reg && power_save_i) begin
        freeze_reg <= 1'b1;
      end else if (osc_rise || !as_reg) begin
        freeze_reg <= 1'b0;
      end
      if (!freeze_reg && !(as_reg && power_save_i)) begin
        frozen_reg <= count_reg;
      end
    end
  end

  assign count_view = freeze_reg ? frozen_reg : count_reg;

  // Wake sequencer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_state_reg <= atc_pkg::WK_IDLE;
      wake_reg       <= 1'b0;
      halt_reg       <= 1'b0;
      halt_cnt_reg   <= 3'h0;
    end else begin
      wake_reg <= 1'b0;
      case (wake_state_reg)
        atc_pkg::WK_IDLE: begin
          if (power_save_i && irq_pend) begin
            wake_state_reg <= atc_pkg::WK_WAIT_TICK;
          end
        end
        atc_pkg::WK_WAIT_TICK: begin
          if (tick) begin
            wake_state_reg <= atc_pkg::WK_HALT;
            wake_reg       <= 1'b1;
            halt_reg       <= 1'b1;
            halt_cnt_reg   <= 3'h0;
          end
        end
        atc_pkg::WK_HALT: begin
          halt_cnt_reg <= halt_cnt_reg + 3'h1;
          if (halt_cnt_reg == HALT_LAST) begin
            halt_reg       <= 1'b0;
            wake_state_reg <= atc_pkg::WK_REARM;
          end
        end
        atc_pkg::WK_REARM: begin
          // A sleep before this tick misses its wake-up
          if (tick) begin
            wake_state_reg <= atc_pkg::WK_IDLE;
          end
        end
        default: wake_state_reg <= atc_pkg::WK_IDLE;
      endcase
    end
  end

  assign status_view = {4'h0, as_reg, cnt_busy, cmp_busy, ctl_busy};

  // APB answer one cycle into the access phase
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else if (psel_i && !penable_i) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !addr_hit(paddr_i);
      prdata_reg  <= 32'h0;
      if (!pwrite_i) begin
        case (paddr_i)
          atc_pkg::OFS_STATUS:  prdata_reg <= {24'h0, status_view};
          atc_pkg::OFS_COUNT:   prdata_reg <= {24'h0, count_view};
          atc_pkg::OFS_COMPARE: prdata_reg <= {24'h0, cmp_hold};
          atc_pkg::OFS_CONTROL: prdata_reg <= {24'h0, ctl_hold};
          atc_pkg::OFS_FLAGS:   prdata_reg <= {30'h0, flags_reg};
          atc_pkg::OFS_IRQ_EN:  prdata_reg <= {30'h0, irq_en_reg};
          default:              prdata_reg <= 32'h0;
        endcase
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata_o           = prdata_reg;
  assign pready_o           = pready_reg;
  assign pslverr_o          = pslverr_reg;
  assign compare_pin_o      = pin_reg;
  assign osc_pins_claimed_o = claimed_reg;
  assign compare_irq_o      = cmp_irq_reg;
  assign overflow_irq_o     = ovf_irq_reg;
  assign wake_o             = wake_reg;
  assign cpu_halt_o         = halt_reg;

  AST_PINS_CLAIMED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    as_reg |=> osc_pins_claimed_o) else $error("pins not claimed");

  AST_STATUS_RESERVED: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && paddr_i == atc_pkg::OFS_STATUS
    |=> prdata_o[31:4] == 28'h0 && prdata_o[3] == $past(as_reg))
    else $error("status upper bits not zero");

  AST_CNT_BUSY_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    w_cnt && as_reg |=> cnt_busy) else $error("counter busy not set");

  AST_CMP_BUSY_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    w_cmp && as_reg |=> cmp_busy ##1 cmp_busy)
    else $error("compare busy not set");

  AST_CTL_BUSY_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    w_ctl && as_reg |=> ctl_busy) else $error("control busy not set");

  AST_NO_MATCH_BUSY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cnt_busy || cmp_busy) |-> !match_ev)
    else $error("match while transfer pending");

  AST_FLAG_THREE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    match_ev |-> ##3 flags_reg[atc_pkg::FL_CMP_BIT])
    else $error("compare flag not set three cycles later");

  AST_HALT_FOUR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(cpu_halt_o) |-> cpu_halt_o[*4] ##1 !cpu_halt_o)
    else $error("halt not four cycles");

  AST_CMP_READ_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    psel_i && !penable_i && !pwrite_i && paddr_i == atc_pkg::OFS_COMPARE
    |=> prdata_o[7:0] == $past(cmp_hold))
    else $error("compare read not holding value");

  AST_PIN_ON_MATCH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    match_ev && control_reg[atc_pkg::CTL_TOGGLE_BIT]
    |=> compare_pin_o != $past(compare_pin_o))
    else $error("pin did not change on match");
endmodule

//--- rtl/atc_pkg.sv
// Constants and types shared by the asynchronous timer clock-crossing block
package atc_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_FLAGS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h14;

  // Status register fields
  localparam int unsigned ST_AS_BIT       = 3;
  localparam int unsigned ST_CNT_BUSY_BIT = 2;
  localparam int unsigned ST_CMP_BUSY_BIT = 1;
  localparam int unsigned ST_CTL_BUSY_BIT = 0;

  // Flag and enable fields
  localparam int unsigned FL_CMP_BIT = 0;
  localparam int unsigned FL_OVF_BIT = 1;

  // Control register fields
  localparam int unsigned CTL_RUN_LSB    = 0;
  localparam int unsigned CTL_RUN_MSB    = 2;
  localparam int unsigned CTL_TOGGLE_BIT = 4;

  // Reset values
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic       RST_AS      = 1'b0;
  localparam logic [1:0] RST_FLAGS   = 2'h0;
  localparam logic [1:0] RST_IRQ_EN  = 2'h0;

  // Timing counts
  localparam int unsigned XFER_EDGES       = 2;
  localparam int unsigned FLAG_SYNC_CYCLES = 3;
  localparam int unsigned WAKE_HALT_CYCLES = 4;

  typedef enum logic [1:0] {
    WK_IDLE,
    WK_WAIT_TICK,
    WK_HALT,
    WK_REARM
  } atc_wake_t;
endpackage

//--- rtl/atc_sync3.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
module atc_sync3 (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Asynchronous input
  input  wire logic async_i,
  // Synchronised outputs
  output logic      level_o,
  output logic      rise_o
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  logic rise_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ff1_reg <= 1'b0;
      ff2_reg <= 1'b0;
      ff3_reg <= 1'b0;
    end else begin
      ff1_reg <= async_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // Only accept a change once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end else begin
      if (ff2_reg == ff3_reg) begin
        level_reg <= ff2_reg;
      end
      rise_reg <= (ff2_reg == ff3_reg) && ff2_reg && !level_reg;
    end
  end

  assign level_o = level_reg;
  assign rise_o  = rise_reg;
endmodule

//--- rtl/atc_xfer.sv
// Holding register and timed transfer into the timer domain
module atc_xfer #(
  parameter int unsigned W     = 8,
  parameter int unsigned EDGES = atc_pkg::XFER_EDGES
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // CPU side
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         async_i,
  // Timer clock edge pulse
  input  wire logic         tick_i,
  // Outputs
  output logic [W-1:0]      hold_o,
  output logic              busy_o,
  output logic              load_o
);
  localparam int unsigned CW = $clog2(EDGES + 1);
  localparam logic [CW-1:0] LAST = CW'(EDGES - 1);

  initial begin
    if (EDGES < 1 || W < 1) begin
      $error("atc_xfer: EDGES and W must be at least one");
    end
  end

  logic [W-1:0]  hold_reg;
  logic          busy_reg;
  logic          load_reg;
  logic [CW-1:0] edge_reg;
  logic          fire;

  assign fire = busy_reg && !load_reg && tick_i && (edge_reg == LAST);

  // Private holding register per destination
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hold_reg <= '0;
    end else if (wr_i) begin
      hold_reg <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || wr_i) begin
      edge_reg <= '0;
    end else if (busy_reg && tick_i && edge_reg != LAST) begin
      edge_reg <= edge_reg + CW'(1);
    end
  end

  // Busy drops at the edge the destination loads, never earlier
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (wr_i) begin
      busy_reg <= async_i;
    end else if (load_reg) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= (wr_i && !async_i) || fire;
    end
  end

  assign hold_o = hold_reg;
  assign busy_o = busy_reg;
  assign load_o = load_reg;

  AST_SYNC_LOAD_NEXT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_i && !async_i |=> load_o) else $error("sync write not loaded");

  AST_BUSY_UNTIL_LOAD: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    busy_o && !load_o && !wr_i |=> busy_o) else $error("busy fell early");
endmodule

//--- test/atc_xtal_model.sv
// Watch-crystal stand-in driving the timer oscillator pin
module atc_xtal_model #(
  parameter int unsigned HALF_NS = 40
) (
  // Oscillator run enable, low in power-down
  input  wire logic run_i,
  // Oscillator pin
  output logic      osc_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Odd start offset keeps it out of phase with the system clock
  initial begin
    osc_o = 1'b0;
    #13;
    forever begin
      #(HALF_NS);
      if (run_i) begin
        osc_o = ~osc_o;
      end
    end
  end
endmodule

//--- test/tb_async_timer_clock_crossing.sv
// Self-checking bench for the asynchronous timer clock-crossing block
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("[FAIL] %s expected %h seen %h", nm, (e), (g)); \
    end \
  end

module tb_async_timer_clock_crossing;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i;
  logic        rst_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc;
  logic        psave;
  logic        pdown;
  logic        claimed;
  logic        wake;
  logic        halt;
  logic        pin;
  logic        pin0;
  logic        cmp_irq;
  logic        ovf_irq;
  int          n_wake;
  int          n_halt;
  int          n_wait;
  int          failures;
  int          n_checks;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] q2;
  logic        err;
  logic [7:0]  v;
  logic [7:0]  a;
  logic [7:0]  addr [3];
  time         t0;

  atc_xtal_model xtal (
    .run_i (~pdown),
    .osc_o (osc)
  );

  atc_top uut (
    .sys_clk_i          (sys_clk_i),
    .rst_i              (rst_i),
    .psel_i             (psel),
    .penable_i          (penable),
    .pwrite_i           (pwrite),
    .paddr_i            (paddr),
    .pwdata_i           (pwdata),
    .prdata_o           (prdata),
    .pready_o           (pready),
    .pslverr_o          (pslverr),
    .timer_osc_in_i     (osc),
    .power_save_i       (psave),
    .power_down_i       (pdown),
    .compare_pin_o      (pin),
    .osc_pins_claimed_o (claimed),
    .compare_irq_o      (cmp_irq),
    .overflow_irq_o     (ovf_irq),
    .wake_o             (wake),
    .cpu_halt_o         (halt)
  );

  // Count one-cycle wake pulses and halt cycles
  always @(posedge sys_clk_i) begin
    if (wake === 1'b1) n_wake++;
    if (halt === 1'b1) n_halt++;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] exp_status(input logic sel,
                                             input logic [2:0] busy);
    return {28'h0, sel, busy};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q   = prdata;
    err = pslverr;
    if (n >= 50) failures++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Software must not rewrite while busy, so every rewrite waits here
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (q[2:0] !== 3'h0 && n < 100);
    `CHK("busy clear", 3'h0, q[2:0])
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #100000;
    failures++;
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    psave = 1'b0;
    pdown = 1'b0;
    failures = 0;
    n_checks = 0;
    n_wake = 0;
    n_halt = 0;
    seed = 32'hb191;
    addr = '{atc_pkg::OFS_CONTROL, atc_pkg::OFS_COMPARE, atc_pkg::OFS_COUNT};
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
    `CHK("status reset", exp_status(1'b0, 3'h0), q)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    // Synchronous mode: no busy, holding value read back
    seed = next_rand(seed);
    v = seed[7:0];
    apb(1'b1, atc_pkg::OFS_COMPARE, {24'h0, v});
    apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
    `CHK("sync status", exp_status(1'b0, 3'h0), q)
    apb(1'b0, atc_pkg::OFS_COMPARE, 32'h0);
    `CHK("sync compare", {24'h0, v}, q)
    // Safe switch to the oscillator clock
    apb(1'b1, atc_pkg::OFS_IRQ_EN, 32'h0);
    apb(1'b1, atc_pkg::OFS_STATUS, 32'hff);
    apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
    `CHK("status async", exp_status(1'b1, 3'h0), q)
    `CHK("pins claimed", 1'b1, claimed)
    for (int k = 0; k < 3; k++) begin
      seed = next_rand(seed);
      v = (k == 0) ? ((seed[7:0] & 8'hef) | 8'h01) : seed[7:0];
      apb(1'b1, addr[k], {24'h0, v});
      t0 = $time;
      apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
      `CHK("busy set", exp_status(1'b1, 3'h1 << k), q)
      wait_idle();
      `CHK("two osc edges", 1'b1, ($time - t0) >= 80)
      apb(1'b0, addr[k], 32'h0);
      if (k < 2) begin
        `CHK("holding read", {24'h0, v}, q)
      end else begin
        `CHK("count loaded", 1'b1, (q[7:0] - v) < 8'h04)
      end
    end
    // Pending compare untouched by a counter write
    seed = next_rand(seed);
    a = seed[7:0];
    apb(1'b1, atc_pkg::OFS_COMPARE, {24'h0, a});
    apb(1'b1, atc_pkg::OFS_COUNT, {24'h0, seed[15:8]});
    apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
    `CHK("both busy", exp_status(1'b1, 3'h6), q)
    wait_idle();
    apb(1'b0, atc_pkg::OFS_COMPARE, 32'h0);
    `CHK("compare kept", {24'h0, a}, q)
    apb(1'b1, atc_pkg::OFS_FLAGS, 32'h3);
    // Live count advances on oscillator ticks
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    q2 = q;
    repeat (40) @(posedge sys_clk_i);
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    `CHK("live count", 1'b1, q !== q2)
    // Sleep with a compare wake-up eight ticks ahead
    apb(1'b1, atc_pkg::OFS_CONTROL, 32'h11);
    wait_idle();
    apb(1'b1, atc_pkg::OFS_IRQ_EN, 32'h1);
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    a = q[7:0] + 8'h08;
    apb(1'b1, atc_pkg::OFS_COMPARE, {24'h0, a});
    wait_idle();
    apb(1'b1, atc_pkg::OFS_FLAGS, 32'h3);
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    q2 = q;
    pin0 = pin;
    psave <= 1'b1;
    n_wait = 0;
    do begin
      @(posedge sys_clk_i);
      n_wait++;
    end while (wake !== 1'b1 && n_wait < 1000);
    psave <= 1'b0;
    `CHK("wake irq", 1'b1, cmp_irq)
    `CHK("pin toggled", ~pin0, pin)
    // Read lands before the next oscillator rise
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    `CHK("stale count", 1'b1, (q[7:0] - q2[7:0]) < 8'h02)
    repeat (8) @(posedge sys_clk_i);
    `CHK("wake pulses", 32'h1, n_wake)
    `CHK("halt cycles", 32'h4, n_halt)
    apb(1'b1, atc_pkg::OFS_CONTROL, 32'h11);
    wait_idle();
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    `CHK("thawed count", 1'b1, (q[7:0] - a - 8'h01) < 8'h10)
    // Power-down stops the ticks
    pdown <= 1'b1;
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    q2 = q;
    repeat (40) @(posedge sys_clk_i);
    apb(1'b0, atc_pkg::OFS_COUNT, 32'h0);
    `CHK("power-down stop", q2, q)
    pdown <= 1'b0;
    apb(1'b1, atc_pkg::OFS_STATUS, 32'h0);
    apb(1'b0, atc_pkg::OFS_STATUS, 32'h0);
    `CHK("status sync", exp_status(1'b0, 3'h0), q)
    @(posedge sys_clk_i);
    `CHK("pins free", 1'b0, claimed)
    // Sync ticks every cycle, so a wrap comes within 256 cycles
    apb(1'b1, atc_pkg::OFS_FLAGS, 32'h3);
    apb(1'b1, atc_pkg::OFS_IRQ_EN, 32'h3);
    repeat (300) @(posedge sys_clk_i);
    `CHK("overflow irq", 1'b1, ovf_irq)
    `CHK("compare irq", 1'b1, cmp_irq)
    final_report();
  end
endmodule
